// ---- fjtp_test_port.v ----
// Behaviour
// - Scan input captured on each test-clock rise in a shift state
// - Scan output changes only on test-clock falls; test reset also releases its driver
// - Scan output three-state, carries internal register data
// - Undriven mode select reads as one
// - Test reset initialises controller without test clock
// - Two chains: framers 1-8 and 9-16
`timescale 1ns/1ps
`include "fjtp_map.vh"

module fjtp_test_port #(
	parameter CHAIN_BITS = 8
) (
	input  wire                      sys_clk_i,
	input  wire                      rst_n_i,
	input  wire                      tck_i,
	input  wire                      tms_i,
	input  wire                      trst_n_i,
	input  wire                      scan_in_low_framers_i,
	input  wire                      scan_in_high_framers_i,
	input  wire [2*CHAIN_BITS-1:0]   framer_status_i,
	output reg                       scan_out_low_framers_o,
	output reg                       scan_out_low_framers_oe_o,
	output reg                       scan_out_high_framers_o,
	output reg                       scan_out_high_framers_oe_o,
	output reg  [2*CHAIN_BITS-1:0]   framer_ctrl_o,
	output reg  [`FJTP_ST_W-1:0]     tap_state_o
);

	localparam NCH = 2;

	// Pin synchroniser stages and filtered levels
	reg  [`FJTP_PIN_W-1:0]       pin_s1;
	reg  [`FJTP_PIN_W-1:0]       pin_s2;
	reg  [`FJTP_PIN_W-1:0]       pin_s3;
	reg  [`FJTP_PIN_W-1:0]       pin_f;
	wire [`FJTP_PIN_W-1:0]       pin_raw;
	wire [`FJTP_PIN_W-1:0]       next_pin_f;
	reg                          tck_prev;
	wire                         tck_rise;
	wire                         tck_fall;
	wire [`FJTP_ST_W-1:0]        state;

	// Per-chain storage, chain 0 low framers, chain 1 high framers
	reg  [NCH*`FJTP_IR_W-1:0]    ir;
	reg  [NCH*`FJTP_IR_W-1:0]    ir_sh;
	reg  [NCH-1:0]               bypass_sh;
	reg  [NCH*`FJTP_ID_W-1:0]    id_sh;
	reg  [NCH*CHAIN_BITS-1:0]    fr_sh;
	wire [NCH-1:0]               tdi;
	reg  [NCH-1:0]               next_out;
	reg                          shifting;
	// Loop indices, one per process, so no variable has two drivers
	integer                      c_ir;
	integer                      c_dr;
	integer                      c_out;

	// Serial bit presented by one chain in the current state
	function chain_bit;
		input [`FJTP_ST_W-1:0] st;
		input [`FJTP_IR_W-1:0] op;
		input                  ir0;
		input                  bp;
		input                  id0;
		input                  fr0;
		begin
			if (st == `FJTP_ST_SH_IR) begin
				chain_bit = ir0;
			end else begin
				case (op)
					`FJTP_OP_IDCODE: chain_bit = id0;
					`FJTP_OP_FRAMER: chain_bit = fr0;
					default:         chain_bit = bp;
				endcase
			end
		end
	endfunction

	// Pin bundle, one bit per level that crosses into the system clock
	assign pin_raw = {trst_n_i, scan_in_high_framers_i, scan_in_low_framers_i, tms_i, tck_i};

	// A level counts only once stages two and three agree; else hold
	assign next_pin_f = (pin_s2 & pin_s3) | (pin_f & (pin_s2 ^ pin_s3));

	// Synchroniser; resets to ones so floating pins look pulled up
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1 <= `FJTP_PIN_RST;
			pin_s2 <= `FJTP_PIN_RST;
			pin_s3 <= `FJTP_PIN_RST;
			pin_f  <= `FJTP_PIN_RST;
		end else begin
			// Only stage two reads stage one, so metastability stays there
			pin_s1 <= pin_raw;
			pin_s2 <= pin_s1;
			pin_s3 <= pin_s2;
			pin_f  <= next_pin_f;
		end
	end

	// Test-clock edge finder on the filtered level
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tck_prev <= 1'b1;
		end else begin
			tck_prev <= pin_f[`FJTP_PIN_TCK];
		end
	end

	// Edges show in the same clock as the filtered level changes; each test-clock level needs two clocks
	assign tck_rise = pin_f[`FJTP_PIN_TCK] & ~tck_prev;
	assign tck_fall = ~pin_f[`FJTP_PIN_TCK] & tck_prev;
	assign tdi      = {pin_f[`FJTP_PIN_TDI_HI], pin_f[`FJTP_PIN_TDI_LO]};

	// One controller drives both chains; they share clock and mode select
	fjtp_tap_fsm u_tap (
		.sys_clk_i (sys_clk_i),
		.rst_n_i   (rst_n_i),
		.trst_n_i  (pin_f[`FJTP_PIN_TRST]),
		.step_i    (tck_rise),
		.tms_i     (pin_f[`FJTP_PIN_TMS]),
		.state_o   (state)
	);

	// Instruction path: capture, shift and update on test-clock rises
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ir    <= {NCH{`FJTP_OP_IDCODE}};
			ir_sh <= {NCH{`FJTP_IR_CAPTURE}};
		end else if (!pin_f[`FJTP_PIN_TRST] || (tck_rise && state == `FJTP_ST_RESET)) begin
			ir <= {NCH{`FJTP_OP_IDCODE}};
		end else if (tck_rise) begin
			for (c_ir = 0; c_ir < NCH; c_ir = c_ir + 1) begin
				case (state)
					`FJTP_ST_CAP_IR: ir_sh[c_ir*`FJTP_IR_W +: `FJTP_IR_W] <= `FJTP_IR_CAPTURE;
					`FJTP_ST_SH_IR:  ir_sh[c_ir*`FJTP_IR_W +: `FJTP_IR_W] <=
						{tdi[c_ir], ir_sh[c_ir*`FJTP_IR_W+1 +: `FJTP_IR_W-1]};
					`FJTP_ST_UPD_IR: ir[c_ir*`FJTP_IR_W +: `FJTP_IR_W] <=
						ir_sh[c_ir*`FJTP_IR_W +: `FJTP_IR_W];
					default:         ir_sh <= ir_sh;
				endcase
			end
		end
	end

	// Data path: register picked by each chain's own instruction
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bypass_sh     <= {NCH{1'b0}};
			id_sh         <= {(NCH*`FJTP_ID_W){1'b0}};
			fr_sh         <= {(NCH*CHAIN_BITS){1'b0}};
			framer_ctrl_o <= {(NCH*CHAIN_BITS){1'b0}};
		end else if (!pin_f[`FJTP_PIN_TRST]) begin
			framer_ctrl_o <= {(NCH*CHAIN_BITS){1'b0}};
		end else if (tck_rise) begin
			for (c_dr = 0; c_dr < NCH; c_dr = c_dr + 1) begin
				if (state == `FJTP_ST_CAP_DR) begin
					bypass_sh[c_dr] <= 1'b0;
					id_sh[c_dr*`FJTP_ID_W +: `FJTP_ID_W] <= `FJTP_ID_VALUE;
					// Each chain sees only its own eight framers
					fr_sh[c_dr*CHAIN_BITS +: CHAIN_BITS] <=
						framer_status_i[c_dr*CHAIN_BITS +: CHAIN_BITS];
				end else if (state == `FJTP_ST_SH_DR) begin
					case (ir[c_dr*`FJTP_IR_W +: `FJTP_IR_W])
						`FJTP_OP_IDCODE: id_sh[c_dr*`FJTP_ID_W +: `FJTP_ID_W] <=
							{tdi[c_dr], id_sh[c_dr*`FJTP_ID_W+1 +: `FJTP_ID_W-1]};
						`FJTP_OP_FRAMER: fr_sh[c_dr*CHAIN_BITS +: CHAIN_BITS] <=
							{tdi[c_dr], fr_sh[c_dr*CHAIN_BITS+1 +: CHAIN_BITS-1]};
						default:         bypass_sh[c_dr] <= tdi[c_dr];
					endcase
				end else if (state == `FJTP_ST_UPD_DR &&
						ir[c_dr*`FJTP_IR_W +: `FJTP_IR_W] == `FJTP_OP_FRAMER) begin
					// Only a chain holding the framer opcode updates its controls
					framer_ctrl_o[c_dr*CHAIN_BITS +: CHAIN_BITS] <=
						fr_sh[c_dr*CHAIN_BITS +: CHAIN_BITS];
				end
			end
		end
	end

	// Next serial bit per chain and whether a shift state is active
	always @* begin
		shifting = (state == `FJTP_ST_SH_IR) || (state == `FJTP_ST_SH_DR);
		for (c_out = 0; c_out < NCH; c_out = c_out + 1) begin
			next_out[c_out] = chain_bit(state, ir[c_out*`FJTP_IR_W +: `FJTP_IR_W],
				ir_sh[c_out*`FJTP_IR_W], bypass_sh[c_out], id_sh[c_out*`FJTP_ID_W],
				fr_sh[c_out*CHAIN_BITS]);
		end
	end

	// Output stage moves only on test-clock falls or test reset, so the controller
	// sees a settled bit at its next rise; driver released at the first fall outside shift
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			scan_out_low_framers_o     <= 1'b0;
			scan_out_low_framers_oe_o  <= 1'b0;
			scan_out_high_framers_o    <= 1'b0;
			scan_out_high_framers_oe_o <= 1'b0;
		end else if (!pin_f[`FJTP_PIN_TRST]) begin
			scan_out_low_framers_oe_o  <= 1'b0;
			scan_out_high_framers_oe_o <= 1'b0;
		end else if (tck_fall) begin
			scan_out_low_framers_o     <= next_out[0];
			scan_out_low_framers_oe_o  <= shifting;
			scan_out_high_framers_o    <= next_out[1];
			scan_out_high_framers_oe_o <= shifting;
		end
	end

	// Registered copy of the controller state for observation
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tap_state_o <= `FJTP_ST_RESET;
		end else begin
			tap_state_o <= state;
		end
	end

endmodule

// ---- fjtp_map.vh ----
`ifndef FJTP_MAP_VH
`define FJTP_MAP_VH

// Tap controller state codes (four bits, conventional boundary-scan coding)
`define FJTP_ST_W        4
`define FJTP_ST_EX2_DR   4'h0
`define FJTP_ST_EX1_DR   4'h1
`define FJTP_ST_SH_DR    4'h2
`define FJTP_ST_PAU_DR   4'h3
`define FJTP_ST_SEL_IR   4'h4
`define FJTP_ST_UPD_DR   4'h5
`define FJTP_ST_CAP_DR   4'h6
`define FJTP_ST_SEL_DR   4'h7
`define FJTP_ST_EX2_IR   4'h8
`define FJTP_ST_EX1_IR   4'h9
`define FJTP_ST_SH_IR    4'hA
`define FJTP_ST_PAU_IR   4'hB
`define FJTP_ST_IDLE     4'hC
`define FJTP_ST_UPD_IR   4'hD
`define FJTP_ST_CAP_IR   4'hE
`define FJTP_ST_RESET    4'hF

// Instruction register layout and opcodes
`define FJTP_IR_W        2
`define FJTP_IR_CAPTURE  2'h1
`define FJTP_OP_IDCODE   2'h1
`define FJTP_OP_FRAMER   2'h2
`define FJTP_OP_BYPASS   2'h3

// Identification word width and value (value is arbitrary)
`define FJTP_ID_W        32
`define FJTP_ID_VALUE    32'h0000A001

// Pin synchroniser: inputs {trst_n, scan_in_high, scan_in_low, tms, tck}
`define FJTP_PIN_W       5
`define FJTP_PIN_RST     5'h1F
`define FJTP_PIN_TCK     0
`define FJTP_PIN_TMS     1
`define FJTP_PIN_TDI_LO  2
`define FJTP_PIN_TDI_HI  3
`define FJTP_PIN_TRST    4

`endif

// ---- fjtp_tap_fsm.v ----
`timescale 1ns/1ps
`include "fjtp_map.vh"

module fjtp_tap_fsm (
	input  wire                      sys_clk_i,
	input  wire                      rst_n_i,
	input  wire                      trst_n_i,
	input  wire                      step_i,
	input  wire                      tms_i,
	output reg  [`FJTP_ST_W-1:0]     state_o
);

	reg [`FJTP_ST_W-1:0] next_state;

	// Sixteen-state walk, one move per test-clock rise
	always @* begin
		case (state_o)
			`FJTP_ST_RESET:  next_state = tms_i ? `FJTP_ST_RESET  : `FJTP_ST_IDLE;
			`FJTP_ST_IDLE:   next_state = tms_i ? `FJTP_ST_SEL_DR : `FJTP_ST_IDLE;
			`FJTP_ST_SEL_DR: next_state = tms_i ? `FJTP_ST_SEL_IR : `FJTP_ST_CAP_DR;
			`FJTP_ST_CAP_DR: next_state = tms_i ? `FJTP_ST_EX1_DR : `FJTP_ST_SH_DR;
			`FJTP_ST_SH_DR:  next_state = tms_i ? `FJTP_ST_EX1_DR : `FJTP_ST_SH_DR;
			`FJTP_ST_EX1_DR: next_state = tms_i ? `FJTP_ST_UPD_DR : `FJTP_ST_PAU_DR;
			`FJTP_ST_PAU_DR: next_state = tms_i ? `FJTP_ST_EX2_DR : `FJTP_ST_PAU_DR;
			`FJTP_ST_EX2_DR: next_state = tms_i ? `FJTP_ST_UPD_DR : `FJTP_ST_SH_DR;
			`FJTP_ST_UPD_DR: next_state = tms_i ? `FJTP_ST_SEL_DR : `FJTP_ST_IDLE;
			`FJTP_ST_SEL_IR: next_state = tms_i ? `FJTP_ST_RESET  : `FJTP_ST_CAP_IR;
			`FJTP_ST_CAP_IR: next_state = tms_i ? `FJTP_ST_EX1_IR : `FJTP_ST_SH_IR;
			`FJTP_ST_SH_IR:  next_state = tms_i ? `FJTP_ST_EX1_IR : `FJTP_ST_SH_IR;
			`FJTP_ST_EX1_IR: next_state = tms_i ? `FJTP_ST_UPD_IR : `FJTP_ST_PAU_IR;
			`FJTP_ST_PAU_IR: next_state = tms_i ? `FJTP_ST_EX2_IR : `FJTP_ST_PAU_IR;
			`FJTP_ST_EX2_IR: next_state = tms_i ? `FJTP_ST_UPD_IR : `FJTP_ST_SH_IR;
			`FJTP_ST_UPD_IR: next_state = tms_i ? `FJTP_ST_SEL_DR : `FJTP_ST_IDLE;
			default:         next_state = `FJTP_ST_RESET;
		endcase
	end

	// Test reset wins over any clock step and needs no test-clock edge
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_o <= `FJTP_ST_RESET;
		end else if (!trst_n_i) begin
			state_o <= `FJTP_ST_RESET;
		end else if (step_i) begin
			state_o <= next_state;
		end
	end

endmodule

// ---- fjtp_test_port_asserts.sv ----
`timescale 1ns/1ps
module fjtp_test_port_asserts #(
	parameter CHAIN_BITS = 8
) (
	input wire                    sys_clk_i,
	input wire                    rst_n_i,
	input wire                    tck_i,
	input wire                    trst_n_i,
	input wire                    scan_out_low_framers_o,
	input wire                    scan_out_high_framers_o,
	input wire                    scan_out_low_framers_oe_o,
	input wire [2*CHAIN_BITS-1:0] framer_ctrl_o,
	input wire [3:0]              tap_state_o
);
	reg  [7:0] trst_hist;
	// Test reset history; the filter delays its effect, so wait until it has settled
	always @(posedge sys_clk_i or negedge rst_n_i) begin
		if (!rst_n_i) trst_hist <= 8'hFF;
		else trst_hist <= {trst_hist[6:0], trst_n_i};
	end
	wire       quiet = &trst_hist;
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (!rst_n_i);
	a_trst_state: assert property (!trst_n_i [*8] |-> tap_state_o == 4'hF)
		else $error("tap state not reset by test reset");
	a_trst_clear: assert property (!trst_n_i [*8] |-> framer_ctrl_o == 0 && !scan_out_low_framers_oe_o)
		else $error("test reset left control or enable set");
	a_out_lo_fall: assert property (quiet && $changed(scan_out_low_framers_o) |-> !$past(tck_i, 4))
		else $error("low chain output moved outside a clock fall");
	a_out_hi_fall: assert property (quiet && $changed(scan_out_high_framers_o) |-> !$past(tck_i, 4))
		else $error("high chain output moved outside a clock fall");
	a_state_on_rise: assert property (quiet && $changed(tap_state_o) |-> $past(tck_i, 4))
		else $error("tap state moved outside a clock rise");
	a_oe_in_shift: assert property (quiet && scan_out_low_framers_oe_o |-> tap_state_o inside {4'h2, 4'hA, 4'h1, 4'h9})
		else $error("output driven outside shift");
	a_idle_entry: assert property (quiet && tap_state_o == 4'hC |-> $past(tap_state_o) inside {4'hC, 4'hF, 4'h5, 4'hD})
		else $error("idle entered from an illegal state");
	a_ctrl_update: assert property (quiet && $changed(framer_ctrl_o) |-> ##[0:1] tap_state_o == 4'h5)
		else $error("framer control changed outside update");
	c_shift_dr: cover property (tap_state_o == 4'h2);
	c_shift_ir: cover property (tap_state_o == 4'hA);
	c_trst: cover property (!trst_n_i [*8] ##1 trst_n_i);
endmodule

bind fjtp_test_port fjtp_test_port_asserts #(.CHAIN_BITS(CHAIN_BITS)) i_chk (.sys_clk_i, .rst_n_i,
	.tck_i, .trst_n_i, .scan_out_low_framers_o, .scan_out_high_framers_o,
	.scan_out_low_framers_oe_o, .framer_ctrl_o, .tap_state_o);

// ---- fjtp_ctl.sv ----
`timescale 1ns/1ps
module fjtp_ctl (
	input  wire sys_clk_i,
	input  wire do_lo_i,
	input  wire oe_lo_i,
	input  wire do_hi_i,
	input  wire oe_hi_i,
	output reg  tck_o,
	output reg  tms_o,
	output reg  tdi_lo_o,
	output reg  tdi_hi_o
);
	// A released output carries no pull, so read the opposite of what it holds
	wire seen_lo = oe_lo_i ? do_lo_i : ~do_lo_i;
	wire seen_hi = oe_hi_i ? do_hi_i : ~do_hi_i;
	// Mode select and scan inputs rest high as the pad pull-ups would leave them
	initial begin
		tck_o = 1'b1;
		tms_o = 1'b1;
		tdi_lo_o = 1'b1;
		tdi_hi_o = 1'b1;
	end
	// One test clock of 200 ns; clock rests high between calls, output read late in high phase
	task pulse(input reg m, input reg lo, input reg hi, output reg [1:0] seen);
		begin
			@(negedge sys_clk_i);
			tck_o = 1'b0;
			tms_o = m;
			tdi_lo_o = lo;
			tdi_hi_o = hi;
			#100 tck_o = 1'b1;
			#90 seen = {seen_hi, seen_lo};
		end
	endtask
endmodule

// ---- fjtp_test_port_tb.sv ----
`timescale 1ns/1ps
`include "fjtp_map.vh"
module fjtp_test_port_tb;
	reg         sys_clk = 1'b0;
	reg         rst_n   = 1'b0;
	reg         trst_n  = 1'b1;
	reg  [15:0] status  = 16'h0000;
	wire        tck, tms, di_lo, di_hi, do_lo, do_hi, oe_lo, oe_hi;
	wire [15:0] ctrl;
	wire [3:0]  state;
	reg  [1:0]  seen;
	reg  [31:0] got_lo, got_hi, d_lo, d_hi, rnd;
	integer     miscompares = 0, n_checks = 0, cycles = 0, i, k;
	always #12.5 sys_clk = ~sys_clk;
	fjtp_test_port #(.CHAIN_BITS(8)) i_fjtp_test_port (.sys_clk_i(sys_clk), .rst_n_i(rst_n),
		.tck_i(tck), .tms_i(tms), .trst_n_i(trst_n), .scan_in_low_framers_i(di_lo),
		.scan_in_high_framers_i(di_hi), .framer_status_i(status),
		.scan_out_low_framers_o(do_lo), .scan_out_low_framers_oe_o(oe_lo),
		.scan_out_high_framers_o(do_hi), .scan_out_high_framers_oe_o(oe_hi),
		.framer_ctrl_o(ctrl), .tap_state_o(state));
	fjtp_ctl i_fjtp_ctl (.sys_clk_i(sys_clk), .do_lo_i(do_lo), .oe_lo_i(oe_lo), .do_hi_i(do_hi),
		.oe_hi_i(oe_hi), .tck_o(tck), .tms_o(tms), .tdi_lo_o(di_lo), .tdi_hi_o(di_hi));
	task check(input string what, input [31:0] got, input [31:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				miscompares = miscompares + 1;
				$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
			end
		end
	endtask
	task final_report;
		begin
			$display("checks %0d mismatches %0d", n_checks, miscompares);
			if (miscompares == 0 && n_checks > 0)
				$display("ALL TESTS PASSED");
			else
				$display("TESTS FAILED");
			$finish;
		end
	endtask
	// Hang guard; the whole run needs well under ten thousand cycles
	always @(posedge sys_clk) begin
		cycles = cycles + 1;
		if (cycles == 40000) begin
			miscompares = miscompares + 1;
			final_report;
		end
	end
	// From idle into shift, move n bits, update, back to idle
	task scan(input reg ir, input integer n, input [31:0] lo, input [31:0] hi);
		begin
			got_lo = 0;
			got_hi = 0;
			i_fjtp_ctl.pulse(1'b1, 1'b1, 1'b1, seen);
			if (ir) i_fjtp_ctl.pulse(1'b1, 1'b1, 1'b1, seen);
			i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
			i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
			for (k = 0; k < n; k = k + 1) begin
				i_fjtp_ctl.pulse(k == n - 1, lo[k], hi[k], seen);
				got_lo[k] = seen[0];
				got_hi[k] = seen[1];
			end
			i_fjtp_ctl.pulse(1'b1, 1'b1, 1'b1, seen);
			i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
			// The update rise needs about five clocks to pass the pin filter
			repeat (3) @(negedge sys_clk);
		end
	endtask
	initial begin
		i = $urandom(15);
		repeat (3) @(posedge sys_clk);
		@(negedge sys_clk) rst_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		check("reset state", state, `FJTP_ST_RESET);
		d_lo = $urandom;
		for (i = 0; i < 20; i = i + 1) i_fjtp_ctl.pulse(d_lo[i], 1'b1, 1'b1, seen);
		for (i = 0; i < 5; i = i + 1) i_fjtp_ctl.pulse(1'b1, 1'b1, 1'b1, seen);
		repeat (8) @(negedge sys_clk);
		check("tms walk", state, `FJTP_ST_RESET);
		i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
		repeat (8) @(negedge sys_clk);
		check("idle", state, `FJTP_ST_IDLE);
		$display("walk test done");
		// First pass shifts ones only in its data scans, as an unconnected scan input would
		for (i = 0; i < 4; i = i + 1) begin
			d_lo = (i == 0) ? 32'hFFFFFFFF : $urandom;
			d_hi = (i == 0) ? 32'hFFFFFFFF : $urandom;
			rnd = $urandom;
			@(negedge sys_clk) status = rnd[15:0];
			scan(1'b0, 32, d_lo, d_hi);
			check("id low", got_lo, `FJTP_ID_VALUE);
			check("id high", got_hi, `FJTP_ID_VALUE);
			scan(1'b1, 2, `FJTP_OP_FRAMER, `FJTP_OP_FRAMER);
			check("ir capture", got_lo, `FJTP_IR_CAPTURE);
			scan(1'b0, 8, d_lo, d_hi);
			check("status low", got_lo, status[7:0]);
			check("status high", got_hi, status[15:8]);
			check("ctrl", ctrl, {d_hi[7:0], d_lo[7:0]});
			check("oe idle", oe_lo, 1'b0);
			scan(1'b1, 2, 2'h0, `FJTP_OP_BYPASS);
			scan(1'b0, 9, d_hi, d_lo);
			check("bypass low", got_lo, {d_hi[7:0], 1'b0});
			check("bypass high", got_hi, {d_lo[7:0], 1'b0});
			check("ctrl kept", ctrl, {d_hi[7:0], d_lo[7:0]});
			scan(1'b1, 2, `FJTP_OP_IDCODE, `FJTP_OP_IDCODE);
		end
		$display("chain test done");
		// Test reset in mid-shift, with no test clock running
		scan(1'b1, 2, `FJTP_OP_FRAMER, `FJTP_OP_BYPASS);
		i_fjtp_ctl.pulse(1'b1, 1'b1, 1'b1, seen);
		i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
		i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
		i_fjtp_ctl.pulse(1'b0, 1'b0, 1'b0, seen);
		@(negedge sys_clk) trst_n = 1'b0;
		repeat (10) @(negedge sys_clk);
		check("trst state", state, `FJTP_ST_RESET);
		check("trst oe", {oe_hi, oe_lo}, 2'h0);
		check("trst ctrl", ctrl, 16'h0000);
		trst_n = 1'b1;
		repeat (6) @(negedge sys_clk);
		i_fjtp_ctl.pulse(1'b0, 1'b1, 1'b1, seen);
		scan(1'b0, 32, 32'h00000000, 32'h00000000);
		check("id after trst", got_lo, `FJTP_ID_VALUE);
		$display("trst test done");
		final_report;
	end
endmodule
